// File: hw/cwl_loader.sv
// Configuration word shadow loader with register bus slave
//
// The AXI4-Lite slave port is this design's own decision.
`default_nettype none
module cwl_loader
  import cwl_pkg::*;
#(
  parameter int MEM_KB = 64
) (
  input wire logic MCLK,
  input wire logic RST,
  // AXI4-Lite slave
  input wire logic [23:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [23:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Flash array read port
  output logic FL_REQ,
  output logic [23:0] FL_ADDR,
  input wire logic FL_ACK,
  input wire logic [23:0] FL_RDATA,
  // Page erase observation and config word erase
  input wire logic ERASE_STB,
  input wire logic [23:0] ERASE_ADDR,
  output logic CFG_ERASE,
  // Device reset sources, swap and fetch monitor
  input wire logic DEV_RESET,
  input wire logic SOFT_SWAP,
  input wire logic FETCH_VALID,
  input wire logic [23:0] FETCH_ADDR,
  output logic EXEC_RESET,
  output logic CPU_HOLD,
  // Shadow outputs
  output logic SHADOW_VALID,
  output logic ACTIVE_PANEL,
  output logic [23:0] OPTION_CONFIG_WORD,
  output logic [23:0] CONTEXT_CONFIG_WORD,
  output logic [23:0] PARTITION_SEQUENCE_WORD,
  output logic [1:0] BOOT_MODE_FIELD
);
  import cwl_pkg::*;
  // ***************************************************************
  // Declarations
  // ***************************************************************
  localparam logic [23:0] OPT_A = cwl_opt_addr(MEM_KB);
  localparam logic [23:0] LAST_PAGE = OPT_A & ~(PAGE_SPAN - 24'h000001);
  cwl_state_e state_reg, state_next;
  logic [1:0] idx_reg;
  logic [23:0] seq_a_reg;
  logic [23:0] shadow_reg [NUM_WORDS];
  logic valid_reg;
  logic panel_reg;
  logic load_panel_reg;
  logic dual_reg;
  logic exec_flag_reg;
  logic erased_reg;
  logic start_reg;
  logic rd_done;
  logic [23:0] rd_data;
  logic pick_b;
  logic aw_held_reg, w_held_reg;
  logic [23:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  // ***************************************************************
  // Address decoding
  // ***************************************************************
  function automatic logic [23:0] panel_base(input logic b);
    return b ? PANEL_B_BASE : 24'h000000;
  endfunction
  // Boot word is common; the others live in each panel's own page
  function automatic logic [23:0] word_addr(input logic b,
                                            input logic [1:0] i);
    logic [23:0] a;
    a = panel_base(b) + OPT_A;
    case (i)
      2'd0: word_addr = a;
      2'd1: word_addr = a + CTX_DELTA;
      2'd2: word_addr = a + SEQ_DELTA;
      default: word_addr = BOOT_ADDR;
    endcase
  endfunction
  wire [23:0] act_opt = word_addr(panel_reg, 2'd0);
  wire [23:0] act_seq = word_addr(panel_reg, 2'd2);
  wire fetch_in_cfg = FETCH_VALID &&
    ((FETCH_ADDR >= act_opt && FETCH_ADDR <= act_seq) ||
     FETCH_ADDR == BOOT_ADDR);
  wire ctrl_reload;
  wire reset_evt = DEV_RESET || fetch_in_cfg || ctrl_reload;
  wire erase_hit = ERASE_STB &&
    ((ERASE_ADDR & ~(PAGE_SPAN - 24'h000001)) ==
     panel_base(panel_reg) + LAST_PAGE);
  wire [23:0] rd_addr =
    (state_reg == CWL_ST_SEQA) ? word_addr(1'b0, 2'd2) :
    (state_reg == CWL_ST_SEQB) ? word_addr(1'b1, 2'd2) :
    word_addr(load_panel_reg, idx_reg);
  // ***************************************************************
  // Flash read engine and panel choice
  // ***************************************************************
  cwl_flash_rd u_rd (
    .clk(MCLK),
    .rst(RST),
    .start(start_reg),
    .addr(rd_addr),
    .fl_req(FL_REQ),
    .fl_addr(FL_ADDR),
    .fl_ack(FL_ACK),
    .fl_rdata(FL_RDATA),
    .done(rd_done),
    .data(rd_data)
  );
  cwl_seq_pick u_pick (
    .dual(dual_reg),
    .seq_a(seq_a_reg),
    .seq_b(rd_data),
    .panel_b(pick_b)
  );
  // ***************************************************************
  // Load sequencer
  // ***************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CWL_ST_START:
        // Cut read finishes first, else its word lands in a wrong slot
        if (!FL_REQ && !rd_done) begin
          state_next = dual_reg ? CWL_ST_SEQA : CWL_ST_LOAD;
        end
      CWL_ST_SEQA: if (rd_done) state_next = CWL_ST_SEQB;
      CWL_ST_SEQB: if (rd_done) state_next = CWL_ST_LOAD;
      CWL_ST_LOAD:
        if (rd_done && idx_reg == 2'(NUM_WORDS - 1)) state_next = CWL_ST_RUN;
      CWL_ST_RUN: state_next = CWL_ST_RUN;
      default: state_next = CWL_ST_START;
    endcase
  end
  wire fetching = state_reg == CWL_ST_SEQA || state_reg == CWL_ST_SEQB ||
                  state_reg == CWL_ST_LOAD;
  always_ff @(posedge MCLK) begin
    if (RST || reset_evt) begin
      state_reg <= CWL_ST_START;
      idx_reg <= 2'd0;
      valid_reg <= 1'b0;
      start_reg <= 1'b0;
    end
    else begin
      state_reg <= state_next;
      start_reg <= fetching && !FL_REQ && !rd_done && !start_reg;
      if (state_reg == CWL_ST_LOAD && rd_done) begin
        idx_reg <= idx_reg + 2'd1;
      end
      if (state_next == CWL_ST_RUN && state_reg == CWL_ST_LOAD) begin
        valid_reg <= 1'b1;
      end
    end
  end
  // Panel choice and shadow capture
  always_ff @(posedge MCLK) begin
    if (RST) begin
      seq_a_reg <= SHADOW_RST;
      load_panel_reg <= 1'b0;
      panel_reg <= 1'b0;
      for (int i = 0; i < NUM_WORDS; i++) begin
        shadow_reg[i] <= SHADOW_RST;
      end
    end
    else begin
      if (state_reg == CWL_ST_START) begin
        load_panel_reg <= 1'b0;
      end
      if (state_reg == CWL_ST_SEQA && rd_done) begin
        seq_a_reg <= rd_data;
      end
      if (state_reg == CWL_ST_SEQB && rd_done) begin
        load_panel_reg <= pick_b;
        panel_reg <= pick_b;
      end
      if (state_reg == CWL_ST_START && !dual_reg) begin
        panel_reg <= 1'b0;
      end
      if (state_reg == CWL_ST_LOAD && rd_done) begin
        shadow_reg[idx_reg] <= rd_data;
      end
      // Swap moves execution only; shadows are left as loaded
      if (SOFT_SWAP && state_reg == CWL_ST_RUN && dual_reg) begin
        panel_reg <= !panel_reg;
      end
    end
  end
  // ***************************************************************
  // Reset, erase and fault outputs
  // ***************************************************************
  always_ff @(posedge MCLK) begin
    if (RST) begin
      EXEC_RESET <= 1'b0;
      CPU_HOLD <= 1'b1;
      CFG_ERASE <= 1'b0;
      exec_flag_reg <= 1'b0;
      erased_reg <= 1'b0;
    end
    else begin
      EXEC_RESET <= fetch_in_cfg;
      CPU_HOLD <= !(valid_reg && !reset_evt);
      CFG_ERASE <= erase_hit;
      if (fetch_in_cfg) begin
        exec_flag_reg <= 1'b1;
      end
      if (erase_hit) begin
        erased_reg <= 1'b1;
      end
      else if (state_reg == CWL_ST_LOAD && rd_done) begin
        erased_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge MCLK) begin
    if (RST) begin
      SHADOW_VALID <= 1'b0;
      ACTIVE_PANEL <= 1'b0;
      OPTION_CONFIG_WORD <= SHADOW_RST;
      CONTEXT_CONFIG_WORD <= SHADOW_RST;
      PARTITION_SEQUENCE_WORD <= SHADOW_RST;
      BOOT_MODE_FIELD <= 2'b00;
    end
    else begin
      SHADOW_VALID <= valid_reg;
      ACTIVE_PANEL <= panel_reg;
      OPTION_CONFIG_WORD <= shadow_reg[0];
      CONTEXT_CONFIG_WORD <= shadow_reg[1];
      PARTITION_SEQUENCE_WORD <= shadow_reg[2];
      BOOT_MODE_FIELD <= shadow_reg[3][BOOT_MODE_LSB +: BOOT_MODE_W];
    end
  end
  // ***************************************************************
  // Register bus slave
  // ***************************************************************
  wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID && S_AXI_WREADY;
  wire wr_go = aw_held_reg && w_held_reg && !S_AXI_BVALID;
  wire wr_ctrl = aw_addr_reg == REG_CTRL;
  wire wr_ro = aw_addr_reg == REG_STAT || aw_addr_reg == REG_OPT ||
               aw_addr_reg == REG_CTX || aw_addr_reg == REG_SEQ ||
               aw_addr_reg == REG_BOOT;
  assign ctrl_reload = wr_go && wr_ctrl && w_strb_reg[0] &&
                       w_data_reg[CTRL_RELOAD_BIT];
  wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire [31:0] stat_word = {27'h0000000, erased_reg, exec_flag_reg,
                           panel_reg, fetching, valid_reg};
  wire [31:0] rd_word =
    S_AXI_ARADDR == REG_CTRL ? {31'h00000000, dual_reg} :
    S_AXI_ARADDR == REG_STAT ? stat_word :
    S_AXI_ARADDR == REG_OPT ? {8'h00, shadow_reg[0]} :
    S_AXI_ARADDR == REG_CTX ? {8'h00, shadow_reg[1]} :
    S_AXI_ARADDR == REG_SEQ ? {8'h00, shadow_reg[2]} :
    {8'h00, shadow_reg[3]};
  wire rd_hit = S_AXI_ARADDR == REG_CTRL || S_AXI_ARADDR == REG_STAT ||
                S_AXI_ARADDR == REG_OPT || S_AXI_ARADDR == REG_CTX ||
                S_AXI_ARADDR == REG_SEQ || S_AXI_ARADDR == REG_BOOT;
  always_ff @(posedge MCLK) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 24'h000000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      dual_reg <= CTRL_DUAL_RST;
    end
    else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (wr_ctrl || wr_ro) ? RESP_OKAY : RESP_SLVERR;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        // Mode gates soft swap at once; panel choice changes at the next load
        if (wr_ctrl && w_strb_reg[0]) begin
          dual_reg <= w_data_reg[CTRL_DUAL_BIT];
        end
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end
  always_ff @(posedge MCLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= RESP_OKAY;
    end
    else begin
      if (ar_take) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_hit ? rd_word : 32'h00000000;
        S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: hw/cwl_pkg.sv
// Package: constants for the configuration word shadow loader
`default_nettype none
package cwl_pkg;
  // ***************************************************************
  // Flash word addresses
  // ***************************************************************
  localparam logic [23:0] OPT_ADDR_16K = 24'h002BAC;
  localparam logic [23:0] OPT_ADDR_32K = 24'h0057AC;
  localparam logic [23:0] OPT_ADDR_64K = 24'h00AFAC;
  localparam logic [23:0] CTX_DELTA = 24'h000004;
  localparam logic [23:0] SEQ_DELTA = 24'h000050;
  localparam logic [23:0] BOOT_ADDR = 24'h801000;
  localparam logic [23:0] PANEL_B_BASE = 24'h400000;
  localparam logic [23:0] PAGE_SPAN = 24'h000400;
  // ***************************************************************
  // Register bus map
  // ***************************************************************
  localparam logic [23:0] REG_CTRL = 24'h000000;
  localparam logic [23:0] REG_STAT = 24'h000004;
  localparam logic [23:0] REG_OPT = 24'h00AFAC;
  localparam logic [23:0] REG_CTX = 24'h00AFB0;
  localparam logic [23:0] REG_SEQ = 24'h00AFFC;
  localparam logic [23:0] REG_BOOT = 24'h801000;
  // ***************************************************************
  // Fields and reset values
  // ***************************************************************
  localparam int SEQ_LSB = 0;
  localparam int ISEQ_LSB = 12;
  localparam int SEQ_W = 12;
  localparam int BOOT_MODE_LSB = 0;
  localparam int BOOT_MODE_W = 2;
  localparam int CTRL_DUAL_BIT = 0;
  localparam int CTRL_RELOAD_BIT = 1;
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_PANEL_BIT = 2;
  localparam int STAT_EXEC_BIT = 3;
  localparam int STAT_ERASED_BIT = 4;
  localparam logic [23:0] SHADOW_RST = 24'h000000;
  localparam logic CTRL_DUAL_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int NUM_WORDS = 4;
  typedef enum {
    CWL_ST_START, CWL_ST_SEQA, CWL_ST_SEQB, CWL_ST_LOAD, CWL_ST_RUN
  } cwl_state_e;
  // Option word address for the given memory size in KB
  function automatic logic [23:0] cwl_opt_addr(input int kb);
    if (kb == 16) begin
      return OPT_ADDR_16K;
    end
    else if (kb == 32) begin
      return OPT_ADDR_32K;
    end
    return OPT_ADDR_64K;
  endfunction
endpackage
`default_nettype wire

// File: hw/cwl_flash_rd.sv
// Single word read sequencer toward the flash array
`default_nettype none
module cwl_flash_rd (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [23:0] addr,
  output logic fl_req,
  output logic [23:0] fl_addr,
  input wire logic fl_ack,
  input wire logic [23:0] fl_rdata,
  output logic done,
  output logic [23:0] data
);
  // ***************************************************************
  // Request held until the array answers
  // ***************************************************************
  wire take = fl_req && fl_ack;
  always_ff @(posedge clk) begin
    if (rst) begin
      fl_req <= 1'b0;
      fl_addr <= 24'h000000;
      done <= 1'b0;
      data <= 24'h000000;
    end
    else begin
      done <= take;
      if (take) begin
        fl_req <= 1'b0;
        data <= fl_rdata;
      end
      else if (start && !fl_req) begin
        fl_req <= 1'b1;
        fl_addr <= addr;
      end
    end
  end
endmodule
`default_nettype wire

// File: hw/cwl_seq_pick.sv
// Active panel choice from two boot sequence words
`default_nettype none
module cwl_seq_pick
  import cwl_pkg::*;
(
  input wire logic dual,
  input wire logic [23:0] seq_a,
  input wire logic [23:0] seq_b,
  output logic panel_b
);
  // ***************************************************************
  // A word counts only when its inverted copy matches
  // ***************************************************************
  function automatic logic seq_ok(input logic [23:0] w);
    return w[ISEQ_LSB +: SEQ_W] == ~w[SEQ_LSB +: SEQ_W];
  endfunction
  wire ok_a = seq_ok(seq_a);
  wire ok_b = seq_ok(seq_b);
  wire b_lower = seq_b[SEQ_LSB +: SEQ_W] < seq_a[SEQ_LSB +: SEQ_W];
  // Ties and double faults fall back to panel A
  assign panel_b = dual && ok_b && (!ok_a || b_lower);
endmodule
`default_nettype wire

// File: tb/cwl_loader_asserts.sv
// Checker of the loader's flash, reset and erase timing
`default_nettype none
module cwl_loader_chk
  import cwl_pkg::*;
#(
  parameter int MEM_KB = 64
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic FL_REQ,
  input wire logic [23:0] FL_ADDR,
  input wire logic FL_ACK,
  input wire logic ERASE_STB,
  input wire logic [23:0] ERASE_ADDR,
  input wire logic CFG_ERASE,
  input wire logic SOFT_SWAP,
  input wire logic FETCH_VALID,
  input wire logic [23:0] FETCH_ADDR,
  input wire logic EXEC_RESET,
  input wire logic CPU_HOLD,
  input wire logic SHADOW_VALID,
  input wire logic ACTIVE_PANEL,
  input wire logic [23:0] OPTION_CONFIG_WORD
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************
  // Address helpers
  // ***********************
  localparam logic [23:0] OPT = (MEM_KB == 16) ? OPT_ADDR_16K :
    (MEM_KB == 32) ? OPT_ADDR_32K : OPT_ADDR_64K;
  wire logic [23:0] pg = (ACTIVE_PANEL ? PANEL_B_BASE : 24'h000000) + OPT;
  wire logic [23:0] rel = FL_ADDR & ~PANEL_B_BASE;
  wire logic addr_ok = FL_ADDR == BOOT_ADDR || rel == OPT ||
    rel == OPT + CTX_DELTA || rel == OPT + SEQ_DELTA;
  wire logic last_pg = ERASE_STB && ERASE_ADDR[23:10] == pg[23:10];
  wire logic cfg_fetch = FETCH_VALID && FETCH_ADDR == BOOT_ADDR;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  a_req_held: assert property (FL_REQ && !FL_ACK |=> $stable(FL_ADDR))
    else $error("flash address moved before answer");
  a_req_release: assert property (FL_REQ && FL_ACK |=> !FL_REQ)
    else $error("flash request kept after answer");
  a_fetch_place: assert property (FL_REQ |-> addr_ok && CPU_HOLD)
    else $error("flash read outside configuration words");
  a_rst_empty: assert property (disable iff (1'b0) RST |=> !SHADOW_VALID)
    else $error("shadows valid right after reset");
  a_hold_release: assert property ($fell(CPU_HOLD) |-> SHADOW_VALID)
    else $error("processor freed before load finished");
  a_exec_reset: assert property (cfg_fetch |=> EXEC_RESET)
    else $error("no reset after configuration space fetch");
  a_swap_keeps: assert property (SOFT_SWAP && SHADOW_VALID |=>
    $stable(OPTION_CONFIG_WORD)) else $error("soft swap changed shadows");
  a_erase_cfg: assert property (last_pg |=> CFG_ERASE)
    else $error("last page erase left configuration words");
  a_erase_cause: assert property (CFG_ERASE |-> $past(ERASE_STB))
    else $error("configuration erase without page erase");
  cover property ($rose(SHADOW_VALID));
  cover property (SOFT_SWAP && SHADOW_VALID);
  cover property (EXEC_RESET && CFG_ERASE);
endmodule
`default_nettype wire

// File: tb/cwl_flash_model.sv
// Behavioural flash array answering the loader's word reads
`default_nettype none
module cwl_flash_model
  import cwl_pkg::*;
#(
  parameter logic [23:0] SEQ_A = 24'hFFA005
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [23:0] addr,
  input wire logic [3:0] dly,
  input wire logic [23:0] seq_b,
  input wire logic flip,
  output logic ack,
  output logic [23:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic [23:0] w;
  // Bit 2 programmed as one in every word but the two sequence words
  assign w = addr == OPT_ADDR_64K + SEQ_DELTA ? SEQ_A :
    addr == PANEL_B_BASE + OPT_ADDR_64K + SEQ_DELTA ? seq_b :
    (addr ^ 24'h5A5A5A ^ {24{flip}}) | 24'h000004;
  always_ff @(posedge clk) begin
    if (!rst && req && !ack && cnt == dly) begin
      ack <= 1'b1;
      rdata <= w;
      cnt <= 4'h0;
    end
    else begin
      // Idle bus toggles so stale data can never pass a check
      ack <= 1'b0;
      rdata <= ~rdata;
      cnt <= (!rst && req && !ack) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// File: tb/cwl_loader_tb.sv
// Self-checking testbench of the configuration word shadow loader
`default_nettype none
bind cwl_loader cwl_loader_chk #(.MEM_KB(MEM_KB)) cwl_loader_chk_i (
  .MCLK(MCLK), .RST(RST), .FL_REQ(FL_REQ), .FL_ADDR(FL_ADDR),
  .FL_ACK(FL_ACK), .ERASE_STB(ERASE_STB), .ERASE_ADDR(ERASE_ADDR),
  .CFG_ERASE(CFG_ERASE), .SOFT_SWAP(SOFT_SWAP), .CPU_HOLD(CPU_HOLD),
  .FETCH_VALID(FETCH_VALID), .FETCH_ADDR(FETCH_ADDR),
  .EXEC_RESET(EXEC_RESET), .SHADOW_VALID(SHADOW_VALID),
  .ACTIVE_PANEL(ACTIVE_PANEL), .OPTION_CONFIG_WORD(OPTION_CONFIG_WORD));
module cwl_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cwl_pkg::*;
  localparam logic [23:0] SEQ_A = 24'hFFA005;
  logic mclk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic arv = 1'b0, rry = 1'b0, ers = 1'b0, dres = 1'b0, swp = 1'b0;
  logic fv = 1'b0, flip = 1'b0;
  logic [23:0] aw = 24'h000000, ar = 24'h000000, ea = 24'h000000;
  logic [23:0] fa = 24'h000000, sqb = 24'h000000;
  logic [31:0] wd = 32'h00000000;
  logic [3:0] dly = 4'h0;
  wire logic awr, wrdy, bv, arr, rv, flr, fla, cfe, exr, hold, sv, ap;
  wire logic [1:0] br, rr, bm;
  wire logic [31:0] rd;
  wire logic [23:0] fladdr, flrd, optw, ctxw, seqw;
  int err_count = 0;
  int n_compared = 0;
  cwl_loader #(.MEM_KB(64)) cwl_loader_i (
    .MCLK(mclk), .RST(rst), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ar),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .FL_REQ(flr), .FL_ADDR(fladdr), .FL_ACK(fla), .FL_RDATA(flrd),
    .ERASE_STB(ers), .ERASE_ADDR(ea), .CFG_ERASE(cfe), .DEV_RESET(dres),
    .SOFT_SWAP(swp), .FETCH_VALID(fv), .FETCH_ADDR(fa), .EXEC_RESET(exr),
    .CPU_HOLD(hold), .SHADOW_VALID(sv), .ACTIVE_PANEL(ap),
    .OPTION_CONFIG_WORD(optw), .CONTEXT_CONFIG_WORD(ctxw),
    .PARTITION_SEQUENCE_WORD(seqw), .BOOT_MODE_FIELD(bm));
  cwl_flash_model #(.SEQ_A(SEQ_A)) cwl_flash_model_i (
    .clk(mclk), .rst(rst), .req(flr), .addr(fladdr), .dly(dly),
    .seq_b(sqb), .flip(flip), .ack(fla), .rdata(flrd));
  task automatic tally_and_finish;
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end
    else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic give_up;
    err_count++;
    $display("[FAIL] %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic axw(input logic [23:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    aw <= a;
    wd <= d;
    {awv, wv, bry} <= 3'b111;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    if (n == 50) give_up();
    chk(br, RESP_OKAY);
    bry <= 1'b0;
  endtask
  task automatic axr(input logic [23:0] a, output logic [31:0] d);
    int n;
    @(posedge mclk);
    ar <= a;
    {arv, rry} <= 2'b11;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    if (n == 50) give_up();
    d = {rr, rd[29:0]};
    if (rr === RESP_OKAY) d = rd;
    rry <= 1'b0;
  endtask
  // Load always outlasts 8 cycles, so the old valid is skipped
  task automatic wait_load;
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge mclk);
      if (sv === 1'b1 && n > 8) break;
    end
    if (n == 400) give_up();
    repeat (2) @(posedge mclk);
  endtask
  function automatic logic [23:0] fw(input logic [23:0] a);
    return (a ^ 24'h5A5A5A ^ {24{flip}}) | 24'h000004;
  endfunction
  task automatic chk_panel(input logic b, input logic [23:0] seq);
    logic [23:0] base;
    base = b ? PANEL_B_BASE : 24'h000000;
    chk(ap, b);
    chk(optw, fw(base + OPT_ADDR_64K));
    chk(ctxw, fw(base + OPT_ADDR_64K + CTX_DELTA));
    chk(seqw, seq);
    chk(bm, fw(BOOT_ADDR) & 24'h000003);
    chk({sv, hold}, 2'b10);
  endtask
  task automatic s_power_up;
    logic [31:0] d;
    wait_load();
    chk_panel(1'b0, SEQ_A);
    axr(REG_OPT, d);
    chk(d, {8'h00, fw(OPT_ADDR_64K)});
    axr(24'h000010, d);
    chk(d, {RESP_SLVERR, 30'h0});
  endtask
  task automatic s_dev_reset;
    @(posedge mclk);
    {dly, flip, dres} <= {4'h6, 2'b11};
    @(posedge mclk);
    dres <= 1'b0;
    // Second reset while the context word read is still pending
    repeat (17) @(posedge mclk);
    dres <= 1'b1;
    @(posedge mclk);
    dres <= 1'b0;
    wait_load();
    chk_panel(1'b0, SEQ_A);
  endtask
  // Wrong place first, then the config page, to catch loose decodes
  task automatic s_fetch_erase;
    logic [31:0] d;
    @(posedge mclk);
    {fa, ea, fv, ers} <= {24'h000100, 24'h00A800, 2'b11};
    @(posedge mclk);
    {fa, ea} <= {BOOT_ADDR, 24'h00AC10};
    @(posedge mclk);
    {fv, ers} <= 2'b00;
    chk({exr, cfe}, 2'b00);
    @(posedge mclk);
    chk({exr, cfe}, 2'b11);
    wait_load();
    axr(REG_STAT, d);
    chk(d[STAT_EXEC_BIT], 1'b1);
    chk(d, 32'h00000009);
  endtask
  task automatic s_dual_swap;
    logic [23:0] tbl [3];
    int i;
    tbl = '{24'hFFC003, 24'hFF6009, 24'h000001};
    axw(REG_CTRL, 32'h00000001);
    for (i = 0; i < 3; i++) begin
      sqb <= tbl[i];
      axw(REG_CTRL, 32'h00000003);
      wait_load();
      chk_panel(i == 0, i == 0 ? tbl[0] : SEQ_A);
    end
    swp <= 1'b1;
    @(posedge mclk);
    swp <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({ap, seqw}, {1'b1, SEQ_A});
    chk(optw, fw(OPT_ADDR_64K));
  endtask
  initial begin
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (5) @(posedge mclk);
    chk({sv, hold}, 2'b01);
    rst <= 1'b0;
    s_power_up();
    s_dev_reset();
    s_fetch_erase();
    s_dual_swap();
    tally_and_finish();
  end
endmodule
`default_nettype wire
